// ---- logic/aadc_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "aadc_defs.svh"
// Operation
// - Default insertion debounce is 90 ms.
// - Host selects debounce from fixed set.
// - Sleep when empty and override clear.
// - Insertion wakes, detects, then routes switches.
// - Route bias and ground per microphone position.
// - Four keys, press and release events each.
// - Asleep still accepts settings and insertions.
// - Setting override wakes the device.
// - Override cleared while empty returns to sleep.
// - Override lives in settings bit 6.
// - Override keeps automatic detection running.
// - Switch changes wait until detection ends.
// - Switch changes wait while debounce runs.
// - Otherwise override applies switch registers immediately.
// - Clearing override restores latest detection result.
// - No detection run restores no-insertion arrangement.
// - Debounce starts on steady low, restarts on high.
// - Removal opens switches at once unless override, interrupts, 50 ms debounce.
// - Removal aborts debounce, detection and keys.
// - Detection starts from jack or software trigger.
module aadc_ctrl #(
  parameter int INS_DEB0_CYC = `AADC_DEB_SEL0_MS * `AADC_CLK_KHZ,
  parameter int INS_DEB1_CYC = `AADC_DEB_SEL1_MS * `AADC_CLK_KHZ,
  parameter int INS_DEB2_CYC = `AADC_DEB_SEL2_MS * `AADC_CLK_KHZ,
  parameter int INS_DEB3_CYC = `AADC_DEB_SEL3_MS * `AADC_CLK_KHZ,
  parameter int REM_DEB_CYC = `AADC_REM_DEB_MS * `AADC_CLK_KHZ
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic jack_sense_n,
  input wire logic mic_on_sleeve,
  input wire logic mic_on_ring2,
  input wire logic [3:0] key_level,
  input wire logic [7:0] settings1,
  input wire logic [1:0] deb_sel,
  input wire logic auto_det_en,
  input wire logic sw_trigger,
  input wire logic key_det_en,
  input wire logic [3:0] switch_regs,
  input wire logic event_clear,
  output logic [3:0] switch_out,
  output logic mic_bias_line,
  output logic mic_signal_pin,
  output logic audio_ground_pin,
  output logic microphone_found_output,
  output logic int_out,
  output logic ins_rem_event,
  output logic [7:0] key_events,
  output logic res_3pole,
  output logic res_4std,
  output logic res_4alt,
  output logic sleeping,
  output logic trigger_busy,
  output aadc_pkg::aadc_state_t state_out
);
  import aadc_pkg::*;

  // Synchronised versions of every pin-level input.
  logic [6:0] pins_s;
  // Jack sense is active low: low means an accessory sits in the jack.
  logic sense_low;
  logic sleeve_s;
  logic ring2_s;
  logic [3:0] keys_s;
  // Current control state and its next value.
  aadc_state_t state;
  aadc_state_t next_state;
  // Shared countdown for both debounce intervals.
  logic [31:0] deb_cnt;
  // Latest detection outcome, and whether any detection ran since insertion.
  aadc_result_t result;
  logic det_done;
  // Pending software trigger, cleared once the detection runs.
  logic trig_pend;
  // Override bit pulled from the settings byte.
  logic override;
  // Applied switch word and the automatic one.
  logic [3:0] auto_sw;
  // Previous key levels for edge detection.
  logic [3:0] keys_q;
  // Detection takes one cycle here: it samples the settled comparators.
  logic det_go;
  // Selected insertion debounce length in cycles.
  logic [31:0] ins_deb_len;

  aadc_sync #(
    .WIDTH(7)
  ) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .async_in({jack_sense_n, mic_on_sleeve, mic_on_ring2, key_level}),
    .sync_out(pins_s)
  );

  assign sense_low = ~pins_s[6];
  assign sleeve_s = pins_s[5];
  assign ring2_s = pins_s[4];
  assign keys_s = pins_s[3:0];
  assign override = settings1[`AADC_SET1_OVERRIDE_BIT];

  // Debounce length from the host select code; code 0 is the 90 ms default.
  always_comb begin
    case (deb_sel)
      2'h0: ins_deb_len = 32'(INS_DEB0_CYC);
      2'h1: ins_deb_len = 32'(INS_DEB1_CYC);
      2'h2: ins_deb_len = 32'(INS_DEB2_CYC);
      2'h3: ins_deb_len = 32'(INS_DEB3_CYC);
      default: ins_deb_len = 32'(INS_DEB0_CYC);
    endcase
  end

  // Detection fires at the end of debounce when enabled, or on a trigger.
  assign det_go = auto_det_en | trig_pend;

  // Next-state logic. Removal outranks everything else.
  always_comb begin
    next_state = state;
    case (state)
      // Asleep, still watching the jack and the override.
      AADC_SLEEP: begin
        if (sense_low) begin
          next_state = AADC_INS_DEB;
        end else if (override) begin
          next_state = AADC_AWAKE;
        end
      end
      // Awake only because of override, jack empty.
      AADC_AWAKE: begin
        if (sense_low) begin
          next_state = AADC_INS_DEB;
        end else if (!override) begin
          next_state = AADC_SLEEP;
        end
      end
      // Insertion debounce: back to idle if the sense line rises.
      AADC_INS_DEB: begin
        if (!sense_low) begin
          next_state = override ? AADC_AWAKE : AADC_SLEEP;
        end else if (deb_cnt == 32'h0) begin
          next_state = det_go ? AADC_DETECT : AADC_ACTIVE;
        end
      end
      // One-cycle detection step.
      AADC_DETECT: begin
        next_state = sense_low ? AADC_ACTIVE : AADC_REM_DEB;
      end
      // Accessory present; a later software trigger reruns detection.
      AADC_ACTIVE: begin
        if (!sense_low) begin
          next_state = AADC_REM_DEB;
        end else if (trig_pend) begin
          next_state = AADC_DETECT;
        end
      end
      // Removal debounce, then sleep unless override holds the device up.
      AADC_REM_DEB: begin
        if (deb_cnt == 32'h0) begin
          next_state = override ? AADC_AWAKE : AADC_SLEEP;
        end
      end
      default: next_state = AADC_SLEEP;
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= AADC_SLEEP;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // Debounce counter. It reloads on entry to each debounce state, and a high sense line ends
  // insertion debounce, so that one only runs down over a continuous low stretch.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      deb_cnt <= 32'h0;
    end else if (clk_en) begin
      if (next_state == AADC_INS_DEB && state != AADC_INS_DEB) begin
        deb_cnt <= ins_deb_len - 32'h1;
      end else if (next_state == AADC_REM_DEB && state != AADC_REM_DEB) begin
        deb_cnt <= 32'(REM_DEB_CYC) - 32'h1;
      end else if (deb_cnt != 32'h0) begin
        deb_cnt <= deb_cnt - 32'h1;
      end
    end
  end

  // Software trigger: latched on request, dropped when detection runs or the
  // accessory goes away. A request in the consuming cycle is kept.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trig_pend <= 1'b0;
    end else if (clk_en) begin
      if (sw_trigger) begin
        trig_pend <= 1'b1;
      end else if (state == AADC_DETECT || state == AADC_REM_DEB) begin
        trig_pend <= 1'b0;
      end
    end
  end

  // Detection result from the microphone comparators. Cleared on removal so
  // a later override release falls back to the no-insertion arrangement.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      result <= AADC_RES_NONE;
      det_done <= 1'b0;
    end else if (clk_en) begin
      if (state == AADC_DETECT && sense_low) begin
        det_done <= 1'b1;
        if (sleeve_s) begin
          result <= AADC_RES_4STD;
        end else if (ring2_s) begin
          result <= AADC_RES_4ALT;
        end else begin
          result <= AADC_RES_3POLE;
        end
      end else if (state == AADC_INS_DEB || next_state == AADC_REM_DEB) begin
        det_done <= 1'b0;
        result <= AADC_RES_NONE;
      end
    end
  end

  // Automatic switch word from the latest detection.
  always_comb begin
    case (result)
      AADC_RES_3POLE: auto_sw = `AADC_SW_3POLE;
      AADC_RES_4STD: auto_sw = `AADC_SW_4STD;
      AADC_RES_4ALT: auto_sw = `AADC_SW_4ALT;
      default: auto_sw = `AADC_SW_NONE;
    endcase
  end

  // Applied switches. During debounce and detection the old value is held, so
  // override and switch writes wait. Removal opens the switches at once unless
  // override owns them.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      switch_out <= `AADC_SW_NONE;
    end else if (clk_en) begin
      if (next_state == AADC_REM_DEB && state != AADC_REM_DEB && !override) begin
        switch_out <= `AADC_SW_NONE;
      end else if (next_state == AADC_SLEEP) begin
        // Sleep always starts from the no-insertion arrangement, even when override was dropped while a
        // debounce still held the switches at the manual word.
        switch_out <= `AADC_SW_NONE;
      end else if (state == AADC_INS_DEB || state == AADC_DETECT || state == AADC_REM_DEB) begin
        switch_out <= switch_out;
      end else if (override) begin
        switch_out <= switch_regs;
      end else if (det_done) begin
        switch_out <= auto_sw;
      end else begin
        switch_out <= `AADC_SW_NONE;
      end
    end
  end

  // Insertion and removal event flag; a new event wins over a clear.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ins_rem_event <= 1'b0;
    end else if (clk_en) begin
      if ((state == AADC_DETECT) || (next_state == AADC_REM_DEB && state != AADC_REM_DEB)) begin
        ins_rem_event <= 1'b1;
      end else if (event_clear) begin
        ins_rem_event <= 1'b0;
      end
    end
  end

  // Key edge capture. The host only enables this after insertion; removal
  // stops it and clears the reference levels.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      keys_q <= 4'h0;
    end else if (clk_en) begin
      keys_q <= (state == AADC_ACTIVE) ? keys_s : 4'h0;
    end
  end

  // One generate entry per key: press at bit 2k, release at bit 2k+1.
  for (genvar k = 0; k < `AADC_NUM_KEYS; k++) begin : g_key
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        key_events[2*k+1:2*k] <= 2'h0;
      end else if (clk_en) begin
        if (key_det_en && state == AADC_ACTIVE) begin
          if (keys_s[k] && !keys_q[k]) begin
            key_events[2*k] <= 1'b1;
          end else if (event_clear) begin
            key_events[2*k] <= 1'b0;
          end
          if (!keys_s[k] && keys_q[k]) begin
            key_events[2*k+1] <= 1'b1;
          end else if (event_clear) begin
            key_events[2*k+1] <= 1'b0;
          end
        end else if (event_clear) begin
          key_events[2*k+1:2*k] <= 2'h0;
        end
      end
    end
  end

  // Status outputs. Sleep is a state of its own, so it can never coexist
  // with the awake-for-override state.
  assign sleeping = (state == AADC_SLEEP);
  assign trigger_busy = trig_pend;
  assign state_out = state;
  assign res_3pole = (result == AADC_RES_3POLE);
  assign res_4std = (result == AADC_RES_4STD);
  assign res_4alt = (result == AADC_RES_4ALT);
  assign int_out = ins_rem_event | (|key_events);
  assign mic_bias_line = switch_out[`AADC_SW_BIAS_BIT];
  assign mic_signal_pin = switch_out[`AADC_SW_MIC_BIT];
  assign audio_ground_pin = switch_out[`AADC_SW_GND_A_BIT] | switch_out[`AADC_SW_GND_B_BIT];
  assign microphone_found_output = res_4std | res_4alt;
endmodule // aadc_ctrl
`default_nettype wire

// ---- logic/aadc_defs.svh ----
`ifndef AADC_DEFS_SVH
`define AADC_DEFS_SVH

// Clock rate in kHz, used to turn millisecond figures into cycle counts.
`define AADC_CLK_KHZ 125000
// Default insertion debounce time in ms.
`define AADC_INS_DEB_MS 90
// Removal debounce time in ms.
`define AADC_REM_DEB_MS 50
// Selectable insertion debounce times in ms, picked by a 2-bit code.
`define AADC_DEB_SEL0_MS 90
`define AADC_DEB_SEL1_MS 30
`define AADC_DEB_SEL2_MS 250
`define AADC_DEB_SEL3_MS 500
// Reset value of the debounce select code (selects the 90 ms entry).
`define AADC_DEB_SEL_RESET 2'h0
// Position of the override bit within the first settings byte.
`define AADC_SET1_OVERRIDE_BIT 6
// Reset value of the first settings byte.
`define AADC_SET1_RESET 8'h00
// Switch word layout: bias, signal pin, ground to contact A, ground to contact B.
`define AADC_SW_BIAS_BIT 0
`define AADC_SW_MIC_BIT 1
`define AADC_SW_GND_A_BIT 2
`define AADC_SW_GND_B_BIT 3
// Switch patterns for each arrangement.
`define AADC_SW_NONE 4'h0
`define AADC_SW_3POLE 4'hC
`define AADC_SW_4STD 4'h7
`define AADC_SW_4ALT 4'hB
// Number of keys.
`define AADC_NUM_KEYS 4

`endif

// ---- logic/aadc_pkg.sv ----
package aadc_pkg;
  // Control state machine states.
  typedef enum logic [2:0] {
    AADC_SLEEP,
    AADC_INS_DEB,
    AADC_DETECT,
    AADC_ACTIVE,
    AADC_REM_DEB,
    AADC_AWAKE
  } aadc_state_t;
  // Detection outcome.
  typedef enum logic [1:0] {
    AADC_RES_NONE,
    AADC_RES_3POLE,
    AADC_RES_4STD,
    AADC_RES_4ALT
  } aadc_result_t;
endpackage

// ---- logic/aadc_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for a bus of asynchronous levels.
module aadc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // First stage; only the second stage reads it.
  logic [WIDTH-1:0] meta;

  // Both stages always run, so a frozen clock enable cannot hold a stale level.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // aadc_sync
`default_nettype wire

// ---- tb/aadc_ctrl_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
// Port-level checker for the accessory control block.
module aadc_ctrl_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic jack_sense_n,
  input wire logic [7:0] settings1,
  input wire logic [3:0] switch_out,
  input wire logic mic_bias_line,
  input wire logic mic_signal_pin,
  input wire logic audio_ground_pin,
  input wire logic microphone_found_output,
  input wire logic int_out,
  input wire logic ins_rem_event,
  input wire logic [7:0] key_events,
  input wire logic res_3pole,
  input wire logic res_4std,
  input wire logic res_4alt,
  input wire logic sleeping,
  input wire aadc_pkg::aadc_state_t state_out
);
  import aadc_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // Five settled samples of an open jack, long enough to pass the synchroniser.
  sequence s_unplugged;
    (jack_sense_n && clk_en) [*5];
  endsequence
  // A busy state must have been left once the jack has stayed open.
  chk_removal_abort: assert property (s_unplugged |->
    !(state_out inside {AADC_INS_DEB, AADC_DETECT, AADC_ACTIVE}))
    else $error("busy state kept after removal");
  chk_sleep_no_switch: assert property (sleeping |-> switch_out == 4'h0)
    else $error("switches closed while asleep");
  chk_override_wakes: assert property (sleeping && settings1[6] && clk_en |-> ##[1:3] !sleeping)
    else $error("asleep with override set");
  // Debounce and detection both hold off every switch change; only a removal, which aborts them, may move the
  // switches on the way out.
  chk_switch_defer: assert property ((state_out == AADC_INS_DEB || state_out == AADC_DETECT) |=>
    $stable(switch_out) || state_out inside {AADC_SLEEP, AADC_REM_DEB})
    else $error("switches changed in debounce or detection");
  chk_removal_opens: assert property (state_out == AADC_REM_DEB && $past(state_out) != AADC_REM_DEB
    && !$past(settings1[6]) |-> switch_out == 4'h0)
    else $error("switches not opened on removal");
  chk_pin_map: assert property (mic_bias_line == switch_out[0] && mic_signal_pin == switch_out[1]
    && audio_ground_pin == (switch_out[2] | switch_out[3]))
    else $error("pins disagree with switch word");
  chk_mic_found: assert property (microphone_found_output == (res_4std | res_4alt))
    else $error("microphone flag disagrees with result");
  chk_result_single: assert property ($onehot0({res_3pole, res_4std, res_4alt}))
    else $error("more than one result flag");
  chk_int_level: assert property (int_out == (ins_rem_event || (|key_events)))
    else $error("interrupt disagrees with event flags");
  chk_freeze_hold: assert property (!clk_en |=> $stable(state_out))
    else $error("state moved while frozen");
endmodule // aadc_ctrl_chk
bind aadc_ctrl aadc_ctrl_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .jack_sense_n(jack_sense_n),
  .settings1(settings1), .switch_out(switch_out), .mic_bias_line(mic_bias_line), .mic_signal_pin(mic_signal_pin),
  .audio_ground_pin(audio_ground_pin), .microphone_found_output(microphone_found_output), .int_out(int_out),
  .ins_rem_event(ins_rem_event), .key_events(key_events), .res_3pole(res_3pole), .res_4std(res_4std),
  .res_4alt(res_4alt), .sleeping(sleeping), .state_out(state_out));
`default_nettype wire

// ---- tb/aadc_jack_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Jack and its comparators: the plugged accessory decides every pin level.
module aadc_jack_model (
  input wire aadc_pkg::aadc_result_t plug,
  input wire logic [3:0] keys,
  output logic jack_sense_n,
  output logic mic_on_sleeve,
  output logic mic_on_ring2,
  output logic [3:0] key_level
);
  import aadc_pkg::*;
  // The sense contact has a pull-up, so an empty jack reads high.
  assign jack_sense_n = (plug == AADC_RES_NONE);
  // Comparators are driven outputs and read low with no microphone.
  assign mic_on_sleeve = (plug == AADC_RES_4STD);
  assign mic_on_ring2 = (plug == AADC_RES_4ALT);
  // Keys only exist on a four-contact headset.
  assign key_level = (plug == AADC_RES_4STD || plug == AADC_RES_4ALT) ? keys : 4'h0;
endmodule // aadc_jack_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the accessory control block.
module tb_top;
  import aadc_pkg::*;
  localparam int DEB[4] = '{20, 10, 30, 40}; // Short debounce counts keep the run brief.
  localparam logic [3:0] SWX[4] = '{4'h0, 4'hC, 4'h7, 4'hB}; // Switch word per accessory kind.
  logic clk_sys, rstn, clk_en, auto_det_en, sw_trigger, key_det_en, event_clear;
  logic [1:0] deb_sel;
  logic [3:0] keys, switch_regs, switch_out, key_level;
  logic [7:0] settings1, key_events;
  aadc_result_t plug;
  aadc_state_t state_out;
  logic jack_sense_n, mic_on_sleeve, mic_on_ring2, mic_bias_line, mic_signal_pin, audio_ground_pin;
  logic microphone_found_output, int_out, ins_rem_event, res_3pole, res_4std, res_4alt, sleeping, trigger_busy;
  int mismatches, n_checks;
  aadc_jack_model jack (.plug(plug), .keys(keys), .jack_sense_n(jack_sense_n), .mic_on_sleeve(mic_on_sleeve),
    .mic_on_ring2(mic_on_ring2), .key_level(key_level));
  aadc_ctrl #(.INS_DEB0_CYC(DEB[0]), .INS_DEB1_CYC(DEB[1]), .INS_DEB2_CYC(DEB[2]), .INS_DEB3_CYC(DEB[3]),
    .REM_DEB_CYC(10)) uut (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .jack_sense_n(jack_sense_n),
    .mic_on_sleeve(mic_on_sleeve), .mic_on_ring2(mic_on_ring2), .key_level(key_level), .settings1(settings1),
    .deb_sel(deb_sel), .auto_det_en(auto_det_en), .sw_trigger(sw_trigger), .key_det_en(key_det_en),
    .switch_regs(switch_regs), .event_clear(event_clear), .switch_out(switch_out), .mic_bias_line(mic_bias_line),
    .mic_signal_pin(mic_signal_pin), .audio_ground_pin(audio_ground_pin),
    .microphone_found_output(microphone_found_output), .int_out(int_out), .ins_rem_event(ins_rem_event),
    .key_events(key_events), .res_3pole(res_3pole), .res_4std(res_4std), .res_4alt(res_4alt),
    .sleeping(sleeping), .trigger_busy(trigger_busy), .state_out(state_out));
  // Inputs move 1 ns after the edge so they never race the design.
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Bounded wait for a state; running out ends the run as a failure.
  task automatic wait_st(input aadc_state_t s);
    for (int i = 0; i < 600 && state_out !== s; i++) tick();
    if (state_out !== s) begin
      cmp("state wait", {5'h0, s}, {5'h0, state_out});
      end_of_test();
    end
  endtask
  task automatic clear_events();
    event_clear = 1'b1;
    tick();
    event_clear = 1'b0;
    tick();
  endtask
  // Every debounce choice, each paired with an accessory kind.
  task automatic sc_debounce();
    int n;
    for (int s = 0; s < 4; s++) begin
      deb_sel = 2'(s);
      plug = aadc_result_t'(s == 0 ? 3 : s);
      wait_st(AADC_INS_DEB);
      n = 0;
      while (state_out === AADC_INS_DEB && n < 100) begin
        n++;
        tick();
      end
      cmp("debounce cycles", 8'(DEB[s]), 8'(n));
      wait_st(AADC_ACTIVE);
      cmp("result flags", 8'(3'h4 >> (plug - 1)), {5'h0, res_3pole, res_4std, res_4alt});
      cmp("mic found", 8'(plug != AADC_RES_3POLE), {7'h0, microphone_found_output});
      tick();
      cmp("auto switch word", {4'h0, SWX[plug]}, {4'h0, switch_out});
      cmp("insert event", 8'h01, {7'h0, ins_rem_event});
      clear_events();
      plug = AADC_RES_NONE;
      wait_st(AADC_REM_DEB);
      cmp("removal switch word", 8'h00, {4'h0, switch_out});
      cmp("removal interrupt", 8'h01, {7'h0, int_out});
      wait_st(AADC_SLEEP);
      clear_events();
    end
    deb_sel = 2'h0;
  endtask
  // Keys are refused until enabled, then each reports press and release.
  task automatic sc_keys();
    plug = AADC_RES_4STD;
    wait_st(AADC_ACTIVE);
    clear_events();
    keys = 4'h1;
    tick(6);
    cmp("key disabled", 8'h00, key_events);
    keys = 4'h0;
    // Let the release pass the synchroniser first, or it would count as an event once enabled.
    tick(6);
    key_det_en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      keys = 4'(1 << k);
      tick(6);
      cmp("key press", 8'(1 << (2 * k)), key_events);
      keys = 4'h0;
      tick(6);
      cmp("key release", 8'(3 << (2 * k)), key_events);
      clear_events();
    end
    key_det_en = 1'b0;
    plug = AADC_RES_NONE;
    wait_st(AADC_SLEEP);
    clear_events();
  endtask
  // Manual switching: wake, defer, apply, restore and return to sleep.
  task automatic sc_manual();
    switch_regs = 4'hF;
    settings1 = 8'h40;
    wait_st(AADC_AWAKE);
    cmp("awake switch word", 8'h0F, {4'h0, switch_out});
    settings1 = 8'h00;
    wait_st(AADC_SLEEP);
    auto_det_en = 1'b0;
    plug = AADC_RES_3POLE;
    wait_st(AADC_INS_DEB);
    settings1 = 8'h40;
    tick(3);
    cmp("deferred override", 8'h00, {4'h0, switch_out});
    wait_st(AADC_ACTIVE);
    tick(2);
    cmp("override applied", 8'h0F, {4'h0, switch_out});
    settings1 = 8'h00;
    tick(2);
    cmp("no detection restore", 8'h00, {4'h0, switch_out});
    settings1 = 8'h40;
    tick(2);
    sw_trigger = 1'b1;
    tick();
    cmp("trigger pending", 8'h01, {7'h0, trigger_busy});
    sw_trigger = 1'b0;
    tick(8);
    cmp("trigger consumed", 8'h00, {7'h0, trigger_busy});
    cmp("trigger result", 8'h04, {5'h0, res_3pole, res_4std, res_4alt});
    cmp("override kept", 8'h0F, {4'h0, switch_out});
    settings1 = 8'h00;
    tick(2);
    cmp("detection restore", 8'h0C, {4'h0, switch_out});
    settings1 = 8'h40;
    plug = AADC_RES_NONE;
    wait_st(AADC_AWAKE);
    cmp("override kept on removal", 8'h0F, {4'h0, switch_out});
    settings1 = 8'h00;
    wait_st(AADC_SLEEP);
    auto_det_en = 1'b1;
    clear_events();
  endtask
  // Frozen clock enable, then removal in mid-debounce.
  task automatic sc_abort();
    clk_en = 1'b0;
    plug = AADC_RES_4STD;
    tick(8);
    cmp("frozen state", {5'h0, AADC_SLEEP}, {5'h0, state_out});
    clk_en = 1'b1;
    wait_st(AADC_INS_DEB);
    tick(3);
    plug = AADC_RES_NONE;
    // A removal inside the insertion debounce drops straight back to idle, with no removal debounce.
    wait_st(AADC_SLEEP);
    cmp("aborted result", 8'h00, {5'h0, res_3pole, res_4std, res_4alt});
    cmp("aborted switch word", 8'h00, {4'h0, switch_out});
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    auto_det_en = 1'b1;
    {sw_trigger, key_det_en, event_clear, deb_sel, keys, switch_regs, settings1} = '0;
    plug = AADC_RES_NONE;
    repeat (12) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    tick(3);
    cmp("reset outputs", 8'h80, {sleeping, int_out, 2'h0, switch_out});
    sc_debounce();
    sc_keys();
    sc_manual();
    sc_abort();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
